// ==== verilog/beam_permit_latch.sv ====
// Beam permit latch with pre-extraction and post-delivery protection
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module beam_permit_latch (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic DELIVERY_SOON_I,
  input wire logic EXTRACT_I,
  input wire permit_pkg::ready_s READY_I,
  input wire logic RESULT_VALID_I,
  input wire permit_pkg::result_s RESULT_I,
  output logic KICKER_FIRE_EN_O,
  output logic BEAM_ABORT_PATH_O,
  output logic INHIBIT_O,
  output logic IRQ_O
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_n;
  reset_sync u_reset_sync (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .rst_n_o(rst_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic ready_good(input permit_pkg::ready_s r);
    ready_good = r.magnet_flat_top & r.orbit_ok & r.kicker_charge_ok & r.accel_voltage_ok;
  endfunction

  function automatic logic loss_bad(input permit_pkg::result_s r);
    loss_bad = !(r.total_loss_ok & r.local_loss_ok);
  endfunction

  // ----------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [7:0] thr_expert_reg;
  logic [7:0] thr_safety_reg;
  logic [19:0] win_len_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic pre_trip_reg;
  logic post_trip_reg;
  logic [7:0] loss_count_reg;
  permit_pkg::auth_e auth_reg;
  permit_pkg::auth_e auth_next;
  permit_pkg::cycle_e state_reg;
  logic [19:0] win_cnt_reg;
  logic checked_ok_reg;
  logic wr_en;
  logic rd_en;
  logic reset_req;
  logic reset_ok;
  logic [1:0] reset_level;
  logic pre_fail;
  logic post_fail;
  logic post_loss;
  logic [3:0] irq_set;
  logic [7:0] loss_count_next;

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & PENABLE_I & !PWRITE_I;
  assign reset_req = wr_en && PADDR_I == permit_pkg::RESET_OFS
    && PWDATA_I[15:0] == permit_pkg::RESET_KEY[15:0];
  assign reset_level = PWDATA_I[permit_pkg::RESET_LEVEL_LSB +: 2];
  assign reset_ok = reset_req && reset_level >= auth_reg; // [R8]

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= permit_pkg::CTRL_RST;
      thr_expert_reg <= permit_pkg::THR_EXPERT_RST;
      thr_safety_reg <= permit_pkg::THR_SAFETY_RST;
      win_len_reg <= permit_pkg::WIN_RST;
      irq_mask_reg <= 4'h0;
    end else if (wr_en) begin
      case (PADDR_I)
        permit_pkg::CTRL_OFS: ctrl_reg <= PWDATA_I[1:0];
        permit_pkg::THRESH_OFS: begin
          thr_expert_reg <= PWDATA_I[permit_pkg::THR_EXPERT_LSB +: 8]; // [R10]
          thr_safety_reg <= PWDATA_I[permit_pkg::THR_SAFETY_LSB +: 8]; // [R10]
        end
        permit_pkg::IRQ_MASK_OFS: irq_mask_reg <= PWDATA_I[3:0];
        permit_pkg::WIN_OFS: win_len_reg <= PWDATA_I[19:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pulse sequencing: readiness window and post-delivery wait
  // ----------------------------------------------------------------
  assign pre_fail = ctrl_reg[permit_pkg::CTRL_PRE_EN_BIT] && state_reg == permit_pkg::ST_CHECK
    && !ready_good(READY_I); // [R2] [R3]
  assign post_loss = RESULT_VALID_I && state_reg == permit_pkg::ST_WAIT_RESULT
    && loss_bad(RESULT_I);
  assign post_fail = ctrl_reg[permit_pkg::CTRL_POST_EN_BIT] && RESULT_VALID_I
    && state_reg == permit_pkg::ST_WAIT_RESULT
    && (loss_bad(RESULT_I) || !RESULT_I.target_position_ok
    || !RESULT_I.target_sensor_ok); // [R5]

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= permit_pkg::ST_IDLE;
      win_cnt_reg <= 20'h00000;
      checked_ok_reg <= 1'b0;
    end else begin
      case (state_reg) // [R1]
        permit_pkg::ST_IDLE: begin
          checked_ok_reg <= 1'b1;
          win_cnt_reg <= 20'h00000;
          if (DELIVERY_SOON_I) begin
            state_reg <= permit_pkg::ST_CHECK;
          end
        end
        permit_pkg::ST_CHECK: begin
          if (pre_fail) begin
            checked_ok_reg <= 1'b0; // [R2]
          end
          if (win_cnt_reg != win_len_reg) begin
            win_cnt_reg <= win_cnt_reg + 20'h00001;
          end
          if (EXTRACT_I) begin
            state_reg <= permit_pkg::ST_WAIT_RESULT;
          end
        end
        permit_pkg::ST_WAIT_RESULT: begin
          if (RESULT_VALID_I) begin
            state_reg <= permit_pkg::ST_IDLE; // [R5]
          end
        end
        default: state_reg <= permit_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trip latches, loss counter and authority level
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pre_trip_reg <= 1'b0;
      post_trip_reg <= 1'b0;
    end else begin
      if (pre_fail) begin
        pre_trip_reg <= 1'b1; // [R7]
      end else if (reset_ok) begin
        pre_trip_reg <= 1'b0; // [R7]
      end
      if (post_fail) begin
        post_trip_reg <= 1'b1; // [R6] [R7]
      end else if (reset_ok) begin
        post_trip_reg <= 1'b0; // [R7]
      end
    end
  end

  // Authority is judged on the count that includes the trip being taken now
  assign loss_count_next = (loss_count_reg != 8'hFF) ? loss_count_reg + 8'h01 : loss_count_reg;

  always_comb begin
    auth_next = permit_pkg::AUTH_OPERATOR;
    if (loss_count_next >= thr_safety_reg) begin
      auth_next = permit_pkg::AUTH_SAFETY; // [R10]
    end else if (loss_count_next >= thr_expert_reg) begin
      auth_next = permit_pkg::AUTH_EXPERT; // [R10]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      loss_count_reg <= 8'h00;
      auth_reg <= permit_pkg::AUTH_OPERATOR;
    end else begin
      if (post_fail && post_loss) begin
        if (loss_count_reg != 8'hFF) begin
          loss_count_reg <= loss_count_reg + 8'h01; // [R8]
        end
      end else if (reset_ok && auth_reg != permit_pkg::AUTH_OPERATOR) begin
        loss_count_reg <= 8'h00; // [R10]
      end
      if (post_fail && post_loss) begin
        auth_reg <= (auth_next > auth_reg) ? auth_next : auth_reg; // [R8]
      end else if (reset_ok) begin
        auth_reg <= permit_pkg::AUTH_OPERATOR; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Kicker and abort outputs
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      KICKER_FIRE_EN_O <= 1'b0;
      BEAM_ABORT_PATH_O <= 1'b1;
      INHIBIT_O <= 1'b1;
    end else begin
      INHIBIT_O <= pre_trip_reg | post_trip_reg | pre_fail | post_fail; // [R7]
      if (state_reg == permit_pkg::ST_CHECK && !pre_fail && checked_ok_reg
          && !pre_trip_reg && !post_trip_reg && ready_good(READY_I)) begin
        KICKER_FIRE_EN_O <= 1'b1; // [R9]
        BEAM_ABORT_PATH_O <= 1'b0;
      end else begin
        KICKER_FIRE_EN_O <= 1'b0; // [R4] [R6] [R9]
        BEAM_ABORT_PATH_O <= 1'b1; // [R4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------
  assign irq_set = {reset_ok, post_fail && post_loss && auth_next > auth_reg, post_fail,
    pre_fail};

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 4'h0;
      IRQ_O <= 1'b0;
    end else begin
      if (wr_en && PADDR_I == permit_pkg::IRQ_STAT_OFS) begin
        irq_stat_reg <= (irq_stat_reg & ~PWDATA_I[3:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // APB read data and answer
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & !PENABLE_I;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        case (PADDR_I)
          permit_pkg::CTRL_OFS: PRDATA_O <= {30'h00000000, ctrl_reg};
          permit_pkg::STATUS_OFS: PRDATA_O <= {8'h00, loss_count_reg, 8'h00, auth_reg,
            state_reg, checked_ok_reg, INHIBIT_O, post_trip_reg, pre_trip_reg};
          permit_pkg::IRQ_STAT_OFS: PRDATA_O <= {28'h0000000, irq_stat_reg};
          permit_pkg::IRQ_MASK_OFS: PRDATA_O <= {28'h0000000, irq_mask_reg};
          permit_pkg::THRESH_OFS: PRDATA_O <= {16'h0000, thr_safety_reg, thr_expert_reg};
          permit_pkg::RESET_OFS: PRDATA_O <= 32'h00000000;
          permit_pkg::WIN_OFS: PRDATA_O <= {12'h000, win_len_reg};
          default: PSLVERR_O <= 1'b1;
        endcase
      end else if (PSEL_I && !PENABLE_I) begin
        case (PADDR_I)
          permit_pkg::CTRL_OFS, permit_pkg::STATUS_OFS, permit_pkg::IRQ_STAT_OFS,
          permit_pkg::IRQ_MASK_OFS, permit_pkg::THRESH_OFS, permit_pkg::RESET_OFS,
          permit_pkg::WIN_OFS: PSLVERR_O <= 1'b0;
          default: PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule
`default_nettype wire

// ==== verilog/permit_pkg.sv ====
// Package of constants, register map and types for the beam permit latch
// Overview of operation
// R1 - Two protection modes run together: pre-extraction check and post-delivery check.
// R2 - Readiness inputs are evaluated in a short window ending before each delivery.
// R3 - Readiness covers magnet flat-top, orbit near kicker, kicker charge, accelerating voltage.
// R4 - Any bad readiness input withholds kicker fire and routes beam to abort path.
// R5 - After each delivered pulse, loss, position and target results are evaluated.
// R6 - An errant delivered pulse blocks every later extraction until cleared.
// R7 - Any trip latches the inhibit until an explicit operator reset; never self-clears.
// R8 - Repeated loss trips are counted and raise the reset authority needed.
// R9 - Permit is high only with no trip latched and all readiness inputs good.
// R10 - Loss count vs thresholds selects authority; clears only at highest level reached.
package permit_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] THRESH_OFS = 8'h10;
  localparam logic [7:0] RESET_OFS = 8'h14;
  localparam logic [7:0] WIN_OFS = 8'h18;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_PRE_EN_BIT = 0;
  localparam int CTRL_POST_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int THR_EXPERT_LSB = 0;
  localparam int THR_SAFETY_LSB = 8;
  localparam logic [7:0] THR_EXPERT_RST = 8'h03;
  localparam logic [7:0] THR_SAFETY_RST = 8'h06;
  localparam logic [31:0] RESET_KEY = 32'h0000A5A5;
  localparam int RESET_LEVEL_LSB = 16;
  localparam int IRQ_PRE_BIT = 0;
  localparam int IRQ_POST_BIT = 1;
  localparam int IRQ_LEVEL_BIT = 2;
  localparam int IRQ_CLEAR_BIT = 3;
  // ----------------------------------------------------------------
  // Timing: readiness window before delivery
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int WIN_US = 2000;
  localparam int WIN_CYC = (WIN_US * (CLK_HZ / 1000000));
  localparam logic [19:0] WIN_RST = 20'(WIN_CYC);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AUTH_OPERATOR, AUTH_EXPERT, AUTH_SAFETY} auth_e;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WAIT_RESULT} cycle_e;
  typedef struct packed {
    logic magnet_flat_top;
    logic orbit_ok;
    logic kicker_charge_ok;
    logic accel_voltage_ok;
  } ready_s;
  typedef struct packed {
    logic total_loss_ok;
    logic local_loss_ok;
    logic target_position_ok;
    logic target_sensor_ok;
  } result_s;
endpackage

// ==== verilog/reset_sync.sv ====
// Two-stage release of the asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic rst_n_o
);
  logic meta_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b0;
      rst_n_o <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      rst_n_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== bench/beam_permit_latch_props.sv ====
// Port checker for the beam permit latch
`timescale 1ns/1ps
`default_nettype none
module beam_permit_latch_props (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic DELIVERY_SOON_I,
  input wire logic EXTRACT_I,
  input wire permit_pkg::ready_s READY_I,
  input wire logic RESULT_VALID_I,
  input wire permit_pkg::result_s RESULT_I,
  input wire logic KICKER_FIRE_EN_O,
  input wire logic BEAM_ABORT_PATH_O,
  input wire logic INHIBIT_O
);
  // ----------------------------------------------------------------
  // Pulse phase tracking and properties
  // ----------------------------------------------------------------
  logic chk_q, wait_q, rst_wr;
  logic [3:0] up_q;
  assign rst_wr = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == permit_pkg::RESET_OFS);
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      chk_q <= 1'b0;
      wait_q <= 1'b0;
      up_q <= 4'h0;
    end else begin
      chk_q <= DELIVERY_SOON_I || (chk_q && !EXTRACT_I);
      wait_q <= EXTRACT_I || (wait_q && !RESULT_VALID_I);
      up_q <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  pready_one_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held longer than one cycle");
  pready_setup_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no answer one cycle after setup");
  slverr_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error flag without ready");
  slverr_zero_a: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("refused access returned data");
  abort_inverse_a: assert property (BEAM_ABORT_PATH_O == !KICKER_FIRE_EN_O)
    else $error("abort path not inverse of fire enable");
  fire_ready_a: assert property (KICKER_FIRE_EN_O |-> !INHIBIT_O && (&$past(READY_I)))
    else $error("fire enable without clean readiness");
  pre_trip_a: assert property (chk_q && !(&READY_I) |-> ##[1:2] INHIBIT_O)
    else $error("bad readiness did not inhibit");
  post_trip_a: assert property (wait_q && RESULT_VALID_I && !(&RESULT_I) |-> ##[1:2] INHIBIT_O)
    else $error("errant pulse did not inhibit");
  inhibit_hold_a: assert property (up_q == 4'hF && INHIBIT_O && !rst_wr && !$past(rst_wr)
    && !$past(rst_wr, 2) |=> INHIBIT_O)
    else $error("inhibit cleared without reset");
  cover property (KICKER_FIRE_EN_O);
  cover property (PSLVERR_O);
  cover property (wait_q && RESULT_VALID_I && !(&RESULT_I));
endmodule
bind beam_permit_latch beam_permit_latch_props props_u (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .DELIVERY_SOON_I(DELIVERY_SOON_I), .EXTRACT_I(EXTRACT_I), .READY_I(READY_I),
  .RESULT_VALID_I(RESULT_VALID_I), .RESULT_I(RESULT_I), .KICKER_FIRE_EN_O(KICKER_FIRE_EN_O),
  .BEAM_ABORT_PATH_O(BEAM_ABORT_PATH_O), .INHIBIT_O(INHIBIT_O));
`default_nettype wire

// ==== bench/beamline_model.sv ====
// Model of the beamline sensors and pulse timing
`timescale 1ns/1ps
`default_nettype none
module beamline_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire permit_pkg::ready_s ready_val_i,
  input wire permit_pkg::result_s result_val_i,
  output logic soon_o,
  output logic extract_o,
  output logic rvalid_o,
  output permit_pkg::ready_s ready_o,
  output permit_pkg::result_s result_o
);
  // ----------------------------------------------------------------
  // Window, extraction and result sequence
  // ----------------------------------------------------------------
  logic [1:0] ph_reg;
  logic [4:0] cnt_reg;
  logic [3:0] pat_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg <= 2'h0;
      cnt_reg <= 5'h0;
      pat_reg <= 4'h5;
      soon_o <= 1'b0;
      extract_o <= 1'b0;
      rvalid_o <= 1'b0;
    end else begin
      soon_o <= 1'b0;
      extract_o <= 1'b0;
      rvalid_o <= 1'b0;
      pat_reg <= ~pat_reg;
      if (ph_reg == 2'h0 && go_i) begin
        soon_o <= 1'b1;
        ph_reg <= 2'h1;
        cnt_reg <= 5'h0;
      end else if (ph_reg != 2'h0) begin
        cnt_reg <= cnt_reg + 5'h1;
        if (cnt_reg == (slow_i ? 5'h0C : 5'h03)) begin
          cnt_reg <= 5'h0;
          ph_reg <= (ph_reg == 2'h1) ? 2'h2 : 2'h0;
          extract_o <= (ph_reg == 2'h1);
          rvalid_o <= (ph_reg == 2'h2);
        end
      end
    end
  end
  // Sensor data hold only while meaningful, churn otherwise
  assign ready_o = (ph_reg == 2'h1 || extract_o) ? ready_val_i : pat_reg;
  assign result_o = rvalid_o ? result_val_i : ~pat_reg;
endmodule
`default_nettype wire

// ==== bench/beam_permit_latch_tb.sv ====
// Self-checking testbench of the beam permit latch
`timescale 1ns/1ps
`default_nettype none
module beam_permit_latch_tb;
  // ----------------------------------------------------------------
  // Signals, model and design
  // ----------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, go, slow;
  logic soon, extract, rvalid, fire, abort, inhibit, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  permit_pkg::ready_s rdy, rdy_v;
  permit_pkg::result_s res, res_v;
  int fails, n_tests;
  integer seed;
  exp_s q[$];
  exp_s e;
  beamline_model model_u (.clk_i(clk), .rst_n_i(arst_n), .go_i(go), .slow_i(slow),
    .ready_val_i(rdy_v), .result_val_i(res_v), .soon_o(soon), .extract_o(extract),
    .rvalid_o(rvalid), .ready_o(rdy), .result_o(res));
  beam_permit_latch dut_u (.REF_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .DELIVERY_SOON_I(soon),
    .EXTRACT_I(extract), .READY_I(rdy), .RESULT_VALID_I(rvalid), .RESULT_I(res),
    .KICKER_FIRE_EN_O(fire), .BEAM_ABORT_PATH_O(abort), .INHIBIT_O(inhibit), .IRQ_O(irq));
  always #12.5 clk = ~clk;
  task automatic end_sim();
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic act, input logic exp);
    n_tests++;
    if (act !== exp) begin
      fails++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, act, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic er);
    int n;
    n = 0;
    q.push_back('{d, m, er});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : $random(seed);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op_reset(input logic [1:0] lvl);
    apb(1'b1, permit_pkg::RESET_OFS, {14'h0, lvl, 16'hA5A5}, 32'h0, 1'b0);
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input logic [3:0] r, input logic [3:0] s, input logic sl, input logic f);
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    @(posedge clk);
    rdy_v <= permit_pkg::ready_s'(r);
    res_v <= permit_pkg::result_s'(s);
    slow <= sl;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      seen = seen | (fire === 1'b1);
      n++;
    end while (rvalid !== 1'b1 && n < 64);
    chk(rvalid, 1'b1);
    chk(seen, f);
    repeat (3) @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // Answer monitor, watchdog and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      n_tests++;
      if ((prdata & e.m) !== (e.d & e.m) || pslverr !== e.e) begin
        fails++;
        $display("unexpected at %0t: read %h err %b", $time, prdata, pslverr);
      end
    end
  end
  initial begin
    #500000;
    fails++;
    end_sim();
  end
  initial begin
    {clk, arst_n, psel, penable, pwrite, go, slow, paddr, pwdata} = '0;
    {rdy_v, res_v, fails, n_tests} = '0;
    seed = 32'h57B9;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, permit_pkg::CTRL_OFS, 32'h3, 32'h3, 1'b0);
    apb(1'b0, permit_pkg::THRESH_OFS, {permit_pkg::THR_SAFETY_RST, permit_pkg::THR_EXPERT_RST},
      32'hFFFF, 1'b0);
    apb(1'b0, permit_pkg::WIN_OFS, {12'h0, permit_pkg::WIN_RST}, 32'hFFFFF, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h1C, $random(seed), 32'h0, 1'b1);
    apb(1'b1, permit_pkg::IRQ_MASK_OFS, 32'h2, 32'h0, 1'b0);
    pulse(4'hF, 4'hF, 1'b0, 1'b1);
    pulse(4'hF, 4'hF, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pulse(4'hF ^ (4'h1 << i), 4'hF, i[0], 1'b0);
      chk(inhibit, 1'b1);
      chk(irq, 1'b0);
      apb(1'b0, permit_pkg::STATUS_OFS, 32'h5, 32'h5, 1'b0);
      op_reset(2'h0);
      chk(inhibit, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      pulse(4'hF, 4'hF ^ (4'h1 << i), i[0], 1'b1);
      chk(inhibit, 1'b1);
      pulse(4'hF, 4'hF, 1'b0, 1'b0);
      if (i == 0) begin
        chk(irq, 1'b1);
        apb(1'b1, permit_pkg::IRQ_STAT_OFS, 32'h2, 32'h0, 1'b0);
        repeat (3) @(negedge clk);
        chk(irq, 1'b0);
      end
      op_reset(2'h0);
      chk(inhibit, 1'b0);
    end
    pulse(4'hF, 4'h7, 1'b0, 1'b1);
    op_reset(2'h0);
    chk(inhibit, 1'b1);
    apb(1'b0, permit_pkg::STATUS_OFS, 32'h00030044, 32'h00FF00C4, 1'b0);
    op_reset(2'h1);
    chk(inhibit, 1'b0);
    apb(1'b0, permit_pkg::STATUS_OFS, 32'h0, 32'h00FF00C7, 1'b0);
    repeat (4) @(posedge clk);
    if (q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: bus answers missing", $time);
    end
    end_sim();
  end
endmodule
`default_nettype wire
